// ==== common/ckg_pkg.sv ====
// Constants shared by the clock generator control register block
`default_nettype none
package ckg_pkg;
	// Serial frame layout: one direction bit, address, one data byte
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam int INSTR_BITS = 16;
	localparam int FRAME_BITS = 24;
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] INSTR_LAST = 5'h0F;
	localparam logic [CNT_W-1:0] FRAME_LAST = 5'h17;
	localparam logic [CNT_W-1:0] DATA_FIRST = 5'h10;
	localparam logic [CNT_W-1:0] FRAME_DONE = 5'h18;

	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_HOLD_RESET = 15'h0002;
	localparam logic [ADDR_W-1:0] OFS_PART_KIND = 15'h0003;
	localparam logic [ADDR_W-1:0] OFS_SERIAL_LOW = 15'h0004;
	localparam logic [ADDR_W-1:0] OFS_SERIAL_HIGH = 15'h0005;
	localparam logic [ADDR_W-1:0] OFS_VARIANT_REV = 15'h0006;
	localparam logic [ADDR_W-1:0] OFS_IF_VERSION = 15'h000B;
	localparam logic [ADDR_W-1:0] OFS_MAKER_LOW = 15'h000C;
	localparam logic [ADDR_W-1:0] OFS_MAKER_HIGH = 15'h000D;
	localparam logic [ADDR_W-1:0] OFS_COMMIT = 15'h000F;
	localparam logic [ADDR_W-1:0] OFS_LOOP_STATUS = 15'h0020;
	localparam logic [ADDR_W-1:0] OFS_REF_STATUS = 15'h0021;

	// Field positions
	localparam int HOLD_BIT = 2;
	localparam int COMMIT_BIT = 0;
	localparam int CAL_BUSY_BIT = 2;
	localparam int AUX_LOCK_BIT = 1;
	localparam int MAIN_LOCK_BIT = 0;
	localparam int REF_FIELD_LSB = 4;

	// Reset and fixed values
	localparam logic HOLD_RESET_VAL = 1'b0;
	localparam logic COMMIT_RESET_VAL = 1'b0;
	localparam logic [3:0] SERIAL_LOW_RSVD = 4'hF;
	localparam logic [1:0] REF_AGREE = 2'h0;
	localparam logic [1:0] REF_DISAGREE = 2'h3;
endpackage : ckg_pkg
`default_nettype wire

// ==== common/ckg_port_if.sv ====
// Register access carrier between the serial port engine and the register file
`default_nettype none
interface ckg_port_if;
	import ckg_pkg::*;
	logic sclk_sync;
	logic cs_active;
	logic sdi_sync;
	logic wr_stb;
	logic rd_stb;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;

	modport port (input sclk_sync, input cs_active, input sdi_sync, input rdata,
		output wr_stb, output rd_stb, output addr, output wdata);
	modport regs (output sclk_sync, output cs_active, output sdi_sync, output rdata,
		input wr_stb, input rd_stb, input addr, input wdata);
endinterface : ckg_port_if
`default_nettype wire

// ==== hw/ckg_serial_port.sv ====
// Serial control port frame engine: instruction, address and one data byte
`default_nettype none
module ckg_serial_port
	import ckg_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	ckg_port_if.port bus,
	output logic sdio_out,
	output logic sdio_oe
);
	logic sclk_d_reg;
	logic [CNT_W-1:0] bit_cnt_reg;
	logic [FRAME_BITS-2:0] shift_in_reg;
	logic is_read_reg;
	logic load_pend_reg;
	logic [DATA_W-1:0] shift_out_reg;
	logic rise;
	logic fall;

	// Edges taken from the second sync stage and its delayed copy
	assign rise = bus.sclk_sync & ~sclk_d_reg;
	assign fall = ~bus.sclk_sync & sclk_d_reg;

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			sclk_d_reg <= 1'b0;
		else
			sclk_d_reg <= bus.sclk_sync;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			bit_cnt_reg <= '0;
			shift_in_reg <= '0;
			is_read_reg <= 1'b0;
		end
		else if (!bus.cs_active)
		begin
			bit_cnt_reg <= '0;
			is_read_reg <= 1'b0;
		end
		else if (rise && bit_cnt_reg != FRAME_DONE)
		begin
			shift_in_reg <= {shift_in_reg[FRAME_BITS-3:0], bus.sdi_sync};
			bit_cnt_reg <= bit_cnt_reg + 5'h01;
			if (bit_cnt_reg == INSTR_LAST)
				is_read_reg <= shift_in_reg[INSTR_BITS-2];
		end
	end

	// Request strobes, one cycle each
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			bus.wr_stb <= 1'b0;
			bus.rd_stb <= 1'b0;
			bus.addr <= '0;
			bus.wdata <= '0;
		end
		else
		begin
			bus.wr_stb <= 1'b0;
			bus.rd_stb <= 1'b0;
			if (bus.cs_active && rise && bit_cnt_reg == INSTR_LAST)
			begin
				bus.addr <= {shift_in_reg[ADDR_W-2:0], bus.sdi_sync};
				bus.rd_stb <= shift_in_reg[INSTR_BITS-2];
			end
			if (bus.cs_active && rise && bit_cnt_reg == FRAME_LAST && !is_read_reg)
			begin
				bus.wdata <= {shift_in_reg[DATA_W-2:0], bus.sdi_sync};
				bus.wr_stb <= 1'b1;
			end
		end
	end

	// Read data shifted out MSB first on falling edges
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			load_pend_reg <= 1'b0;
			shift_out_reg <= '0;
			sdio_out <= 1'b0;
			sdio_oe <= 1'b0;
		end
		else if (!bus.cs_active)
		begin
			load_pend_reg <= 1'b0;
			sdio_oe <= 1'b0;
		end
		else
		begin
			load_pend_reg <= bus.rd_stb;
			if (load_pend_reg)
				shift_out_reg <= bus.rdata;
			else if (fall && is_read_reg && bit_cnt_reg >= DATA_FIRST && bit_cnt_reg < FRAME_DONE)
			begin
				sdio_out <= shift_out_reg[DATA_W-1];
				shift_out_reg <= {shift_out_reg[DATA_W-2:0], 1'b0};
				sdio_oe <= 1'b1;
			end
			else if (fall && bit_cnt_reg == FRAME_DONE)
				sdio_oe <= 1'b0;
		end
	end
endmodule : ckg_serial_port
`default_nettype wire

// ==== hw/ckg_id_status_regs.sv ====
// Identification, commit, hold-reset and status registers behind the serial control port
//
// What this block does
// - Writing one to the hold-reset bit (bit 2) holds chip logic in reset without touching any register value.
// - Offset 0x003 returns a fixed four-bit part kind code in bits 3:0 with the upper nibble reserved.
// - A fixed twelve-bit unit serial code sits in bits 7:4 of 0x004 (low nibble) and all of 0x005.
// - Offset 0x006 returns the silicon variant in its upper nibble and the revision in its lower nibble.
// - Offset 0x00B returns the eight-bit version of the serial control interface standard.
// - A sixteen-bit maker code is returned low byte at 0x00C and high byte at 0x00D.
// - Writing one to bit 0 of 0x00F copies buffered settings into active ones and the bit clears itself.
// - Bit 2 of 0x020 reads one while main loop calibration runs and zero otherwise.
// - Bits 1 and 0 of 0x020 read the lock state of the auxiliary and main loops.
// - With the monitor on, the reference field reads 00 when the active reference is judged valid.
`default_nettype none
module ckg_id_status_regs
	import ckg_pkg::*;
#(
	// Identity values below are arbitrary
	parameter logic [3:0] PART_KIND = 4'hA,
	parameter logic [11:0] UNIT_SERIAL = 12'h9C3,
	parameter logic [3:0] SILICON_VARIANT = 4'h3,
	parameter logic [3:0] SILICON_REVISION = 4'h2,
	parameter logic [7:0] IF_VERSION = 8'h07,
	parameter logic [15:0] MAKER_CODE = 16'hB7E2
)
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe,
	input wire logic main_loop_locked,
	input wire logic aux_loop_locked,
	input wire logic main_loop_cal_busy,
	input wire logic ref_monitor_active,
	input wire logic requested_ref,
	input wire logic active_ref,
	input wire logic [1:0] ref_monitor_code,
	output logic chip_hold_rst,
	output logic commit_pulse
);
	ckg_port_if bus ();

	logic sclk_s1_reg;
	logic sclk_s2_reg;
	logic cs_s1_reg;
	logic cs_s2_reg;
	logic sdi_s1_reg;
	logic sdi_s2_reg;
	logic hold_reg;
	logic commit_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic [7:0] stat_s1_reg;
	logic [7:0] stat_s2_reg;
	logic [1:0] ref_field;
	logic main_lock_s;
	logic aux_lock_s;
	logic cal_busy_s;
	logic mon_active_s;
	logic req_ref_s;
	logic act_ref_s;
	logic [1:0] mon_code_s;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	// Pins are asynchronous to clock: two stages before the frame engine sees them
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			sclk_s1_reg <= 1'b0;
			sclk_s2_reg <= 1'b0;
			cs_s1_reg <= 1'b1;
			cs_s2_reg <= 1'b1;
			sdi_s1_reg <= 1'b0;
			sdi_s2_reg <= 1'b0;
		end
		else
		begin
			sclk_s1_reg <= sclk;
			sclk_s2_reg <= sclk_s1_reg;
			cs_s1_reg <= cs_n;
			cs_s2_reg <= cs_s1_reg;
			sdi_s1_reg <= sdio_in;
			sdi_s2_reg <= sdi_s1_reg;
		end
	end

	assign bus.sclk_sync = sclk_s2_reg;
	assign bus.cs_active = ~cs_s2_reg;
	assign bus.sdi_sync = sdi_s2_reg;
	assign bus.rdata = rdata_reg;

	ckg_serial_port u_port (
		.clock(clock),
		.nrst(nrst),
		.bus(bus.port),
		.sdio_out(sdio_out),
		.sdio_oe(sdio_oe)
	);

	// Status levels from the loop and monitor logic are on other clocks
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			stat_s1_reg <= '0;
			stat_s2_reg <= '0;
		end
		else
		begin
			stat_s1_reg <= {ref_monitor_code, active_ref, requested_ref, ref_monitor_active,
				main_loop_cal_busy, aux_loop_locked, main_loop_locked};
			stat_s2_reg <= stat_s1_reg;
		end
	end

	assign main_lock_s = stat_s2_reg[0];
	assign aux_lock_s = stat_s2_reg[1];
	assign cal_busy_s = stat_s2_reg[2];
	assign mon_active_s = stat_s2_reg[3];
	assign req_ref_s = stat_s2_reg[4];
	assign act_ref_s = stat_s2_reg[5];
	// Two code bits may settle a cycle apart; the host should re-read on a change
	assign mon_code_s = stat_s2_reg[7:6];

	always_comb
	begin
		if (mon_active_s)
			ref_field = mon_code_s;
		else if (req_ref_s == act_ref_s)
			ref_field = REF_AGREE;
		else
			ref_field = REF_DISAGREE;
	end

	// Hold-reset only drives the chip reset; the map itself is untouched
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			hold_reg <= HOLD_RESET_VAL;
		else if (bus.wr_stb && hit(bus.addr, OFS_HOLD_RESET))
			hold_reg <= bus.wdata[HOLD_BIT];
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			chip_hold_rst <= 1'b0;
		else
			chip_hold_rst <= hold_reg;
	end

	// Commit bit lives one cycle; a new write in that cycle sets it again
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			commit_reg <= COMMIT_RESET_VAL;
		else if (bus.wr_stb && hit(bus.addr, OFS_COMMIT) && bus.wdata[COMMIT_BIT])
			commit_reg <= 1'b1;
		else
			commit_reg <= 1'b0;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			commit_pulse <= 1'b0;
		else
			commit_pulse <= bus.wr_stb && hit(bus.addr, OFS_COMMIT) && bus.wdata[COMMIT_BIT];
	end

	// Read mux; unmapped offsets and reserved bits read zero except 0x004 bits 3:0, which read F, and writes elsewhere are dropped
	always_comb
	begin
		rdata_next = '0;
		case (bus.addr)
			OFS_HOLD_RESET:
				rdata_next[HOLD_BIT] = hold_reg;
			OFS_PART_KIND:
				rdata_next = {4'h0, PART_KIND};
			OFS_SERIAL_LOW:
				rdata_next = {UNIT_SERIAL[3:0], SERIAL_LOW_RSVD};
			OFS_SERIAL_HIGH:
				rdata_next = UNIT_SERIAL[11:4];
			OFS_VARIANT_REV:
				rdata_next = {SILICON_VARIANT, SILICON_REVISION};
			OFS_IF_VERSION:
				rdata_next = IF_VERSION;
			OFS_MAKER_LOW:
				rdata_next = MAKER_CODE[7:0];
			OFS_MAKER_HIGH:
				rdata_next = MAKER_CODE[15:8];
			OFS_COMMIT:
				rdata_next[COMMIT_BIT] = commit_reg;
			OFS_LOOP_STATUS:
			begin
				rdata_next[CAL_BUSY_BIT] = cal_busy_s;
				rdata_next[AUX_LOCK_BIT] = aux_lock_s;
				rdata_next[MAIN_LOCK_BIT] = main_lock_s;
			end
			OFS_REF_STATUS:
				rdata_next[REF_FIELD_LSB+1 -: 2] = ref_field;
			default:
				rdata_next = '0;
		endcase
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			rdata_reg <= '0;
		else if (bus.rd_stb)
			rdata_reg <= rdata_next;
	end
endmodule : ckg_id_status_regs
`default_nettype wire

// ==== testbench/ckg_id_status_regs_checker.sv ====
// Port-level assertions for the identification and status register block
`default_nettype none
module ckg_id_status_regs_checker
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic cs_n,
	input wire logic sdio_oe,
	input wire logic chip_hold_rst,
	input wire logic commit_pulse
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);
	AST_COMMIT_SINGLE: assert property (commit_pulse |=> !commit_pulse) else $error("commit pulse too long");
	AST_COMMIT_IDLE: assert property (cs_n [*8] |=> !commit_pulse) else $error("commit pulse without frame");
	AST_COMMIT_NO_DRIVE: assert property (commit_pulse |-> !sdio_oe) else $error("commit during read");
	// Write lands a few clocks after the last sclk rise of the frame, so eight idle cycles are safe
	AST_HOLD_IDLE: assert property (cs_n [*8] ##1 cs_n |-> $stable(chip_hold_rst)) else $error("hold moved idle");
	AST_HOLD_NO_DRIVE: assert property ($changed(chip_hold_rst) |-> !sdio_oe) else $error("hold moved in read");
	AST_RESET_OUT: assert property ($rose(nrst) |-> !chip_hold_rst && !commit_pulse) else $error("outputs after reset");
	AST_OE_IDLE: assert property (cs_n [*4] |-> !sdio_oe) else $error("sdio driven while deselected");
	AST_OE_BYTE: assert property ($rose(sdio_oe) |-> sdio_oe [*8]) else $error("sdio released early");
	cover property (commit_pulse);
	cover property ($rose(chip_hold_rst));
	cover property ($rose(sdio_oe));
endmodule : ckg_id_status_regs_checker
`default_nettype wire

// ==== testbench/ckg_host_model.sv ====
// Host controller model that runs serial control port frames
`default_nettype none
module ckg_host_model
(
	input wire logic clock,
	input wire logic sdio_out,
	input wire logic sdio_oe,
	output var logic sclk,
	output var logic cs_n,
	output var logic sdio_in
);
	timeunit 1ns;
	timeprecision 100ps;
	logic host_oe = 1'b1;
	logic host_bit = 1'b0;
	logic park = 1'b0;
	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
	end
	// Released line toggles so a missing driver never reads as good data
	always @(posedge clock) park <= ~park;
	assign sdio_in = host_oe ? host_bit : (sdio_oe === 1'b1 ? sdio_out : park);
	// Phase is clocks per sclk half period; larger values model a slow host
	task automatic frame(input logic [23:0] word, input int phase, output logic [7:0] rd);
		rd = 8'h00;
		@(posedge clock);
		#1;
		cs_n = 1'b0;
		for (int i = 23; i >= 0; i--)
		begin
			host_bit = word[i];
			host_oe = !(word[23] && i < 8);
			repeat (phase) @(posedge clock);
			#1;
			sclk = 1'b1;
			rd = {rd[6:0], sdio_in};
			repeat (phase) @(posedge clock);
			#1;
			sclk = 1'b0;
		end
		repeat (phase) @(posedge clock);
		#1;
		cs_n = 1'b1;
		host_oe = 1'b1;
		repeat (6) @(posedge clock);
		#1;
	endtask : frame
endmodule : ckg_host_model
`default_nettype wire

// ==== testbench/ckg_id_status_regs_tb.sv ====
// Self-checking testbench for the identification and status register block
`default_nettype none
module ckg_id_status_regs_tb
	import ckg_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// Identity values are arbitrary
	localparam logic [3:0] T_PART = 4'h6;
	localparam logic [11:0] T_SERIAL = 12'h7D9;
	localparam logic [3:0] T_VAR = 4'h2;
	localparam logic [3:0] T_REV = 4'hB;
	localparam logic [7:0] T_IFV = 8'h3E;
	localparam logic [15:0] T_MAKER = 16'hC19A;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic sclk, cs_n, sdio_in, sdio_out, sdio_oe, chip_hold_rst, commit_pulse;
	logic main_loop_locked = 1'b0, aux_loop_locked = 1'b0, main_loop_cal_busy = 1'b0;
	logic ref_monitor_active = 1'b0, requested_ref = 1'b0, active_ref = 1'b0;
	logic [1:0] ref_monitor_code = 2'h0;
	logic [7:0] pulses = 8'h00;
	logic [7:0] got;
	int bad_count = 0;
	int checks = 0;
	initial
	begin
		forever #12.5 clock = ~clock;
	end
	ckg_id_status_regs #(.PART_KIND(T_PART), .UNIT_SERIAL(T_SERIAL), .SILICON_VARIANT(T_VAR),
		.SILICON_REVISION(T_REV), .IF_VERSION(T_IFV), .MAKER_CODE(T_MAKER)) DUT (.clock(clock), .nrst(nrst),
		.sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
		.main_loop_locked(main_loop_locked), .aux_loop_locked(aux_loop_locked),
		.main_loop_cal_busy(main_loop_cal_busy), .ref_monitor_active(ref_monitor_active),
		.requested_ref(requested_ref), .active_ref(active_ref), .ref_monitor_code(ref_monitor_code),
		.chip_hold_rst(chip_hold_rst), .commit_pulse(commit_pulse));
	ckg_host_model host (.clock(clock), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sclk(sclk), .cs_n(cs_n),
		.sdio_in(sdio_in));
	always @(posedge clock) if (commit_pulse === 1'b1) pulses <= pulses + 8'h01;
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		host.frame({1'b0, a, d}, 5, got);
	endtask : wr
	task automatic rd(input logic [14:0] a, input logic [7:0] exp, input int ph = 5);
		host.frame({1'b1, a, 8'h00}, ph, got);
		check(got, exp);
	endtask : rd
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	initial
	begin
		#750000;
		bad_count++;
		report_and_stop();
	end
	initial
	begin
		repeat (3) @(posedge clock);
		#1;
		nrst = 1'b1;
		check(chip_hold_rst, 1'b0);
		check(commit_pulse, 1'b0);
		repeat (3) @(posedge clock);
		rd(OFS_PART_KIND, {4'h0, T_PART});
		rd(OFS_SERIAL_LOW, {T_SERIAL[3:0], 4'hF}, 9);
		rd(OFS_SERIAL_HIGH, T_SERIAL[11:4]);
		rd(OFS_VARIANT_REV, {T_VAR, T_REV});
		rd(OFS_IF_VERSION, T_IFV);
		rd(OFS_MAKER_LOW, T_MAKER[7:0]);
		rd(OFS_MAKER_HIGH, T_MAKER[15:8]);
		wr(OFS_PART_KIND, 8'hFF);
		rd(OFS_PART_KIND, {4'h0, T_PART});
		wr(OFS_MAKER_LOW, 8'h00);
		rd(OFS_MAKER_LOW, T_MAKER[7:0]);
		rd(15'h0010, 8'h00);
		wr(OFS_HOLD_RESET, 8'hFF);
		check(chip_hold_rst, 1'b1);
		rd(OFS_HOLD_RESET, 8'h04);
		rd(OFS_SERIAL_HIGH, T_SERIAL[11:4]);
		wr(OFS_COMMIT, 8'h01);
		check(pulses, 8'h01);
		rd(OFS_COMMIT, 8'h00);
		wr(OFS_COMMIT, 8'h00);
		wr(OFS_COMMIT, 8'hFF);
		check(pulses, 8'h02);
		wr(OFS_HOLD_RESET, 8'h00);
		check(chip_hold_rst, 1'b0);
		for (int v = 0; v < 8; v++)
		begin
			{main_loop_cal_busy, aux_loop_locked, main_loop_locked} = v[2:0];
			rd(OFS_LOOP_STATUS, {5'h00, v[2:0]});
		end
		for (int v = 0; v < 8; v++)
		begin
			ref_monitor_active = v[2];
			{requested_ref, active_ref} = v[1:0];
			ref_monitor_code = v[1:0];
			rd(OFS_REF_STATUS, v[2] ? {2'h0, v[1:0], 4'h0} : (v[1] == v[0] ? 8'h00 : 8'h30));
		end
		// Reset in mid-run must drop the hold and restore the register
		wr(OFS_HOLD_RESET, 8'h04);
		check(chip_hold_rst, 1'b1);
		nrst = 1'b0;
		repeat (2) @(posedge clock);
		#1;
		check(chip_hold_rst, 1'b0);
		nrst = 1'b1;
		repeat (3) @(posedge clock);
		rd(OFS_HOLD_RESET, 8'h00);
		report_and_stop();
	end
endmodule : ckg_id_status_regs_tb
bind ckg_id_status_regs ckg_id_status_regs_checker chk (.clock(clock), .nrst(nrst), .cs_n(cs_n),
	.sdio_oe(sdio_oe), .chip_hold_rst(chip_hold_rst), .commit_pulse(commit_pulse));
`default_nettype wire
